// >>> sps_pkg.sv
// Constants for the serial pin select multiplexer.
// Assumes an 8-bit register port with a 12-bit byte address.
`default_nettype none

package sps_pkg;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;
    localparam logic [11:0] SWAP_CTRL_ADDR = 12'hf57;
    localparam logic [11:0] SEL_CTRL_ADDR = 12'hfcb;

    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] SWAP_CTRL_RESET = 8'h00;
    localparam logic [7:0] SEL_CTRL_RESET = 8'h00;
    localparam logic [7:0] SWAP_CTRL_WMASK = 8'h03;
    localparam logic [7:0] SEL_CTRL_WMASK = 8'hd3;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned PAIR_LSB = 0;
    localparam int unsigned GROUP_BIT = 4;
    localparam int unsigned TIMER_LSB = 6;
    localparam int unsigned SWAP0_BIT = 0;
    localparam int unsigned SWAP1_BIT = 1;

    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SPS_PAIR_ASYNC_TWI = 2'h0,
        SPS_PAIR_ASYNC_CSIO = 2'h1,
        SPS_PAIR_CSIO_TWI = 2'h2,
        SPS_PAIR_RESERVED = 2'h3
    } sps_pair_t;

    typedef enum logic [1:0] {
        SPS_TMR_PORT7_BIT2 = 2'h0,
        SPS_TMR_PORT2_BIT1 = 2'h1,
        SPS_TMR_PORT9_BIT1 = 2'h2,
        SPS_TMR_RESERVED = 2'h3
    } sps_tmr_t;

    // ------------------------------------------------------------
    // Pin indices of the muxed pin vector
    // ------------------------------------------------------------
    localparam int unsigned NPIN = 11;
    localparam logic [3:0] PIN_PORT2_BIT0 = 4'h0;
    localparam logic [3:0] PIN_PORT2_BIT1 = 4'h1;
    localparam logic [3:0] PIN_PORT2_BIT2 = 4'h2;
    localparam logic [3:0] PIN_PORT2_BIT3 = 4'h3;
    localparam logic [3:0] PIN_PORT2_BIT4 = 4'h4;
    localparam logic [3:0] PIN_PORT2_BIT5 = 4'h5;
    localparam logic [3:0] PIN_PORTB_BIT4 = 4'h6;
    localparam logic [3:0] PIN_PORTB_BIT5 = 4'h7;
    localparam logic [3:0] PIN_PORTB_BIT6 = 4'h8;
    localparam logic [3:0] PIN_PORT9_BIT0 = 4'h9;
    localparam logic [3:0] PIN_PORT9_BIT1 = 4'ha;

endpackage

`default_nettype wire

// >>> sps_mux.sv
// Serial pin select multiplexer: two selection registers, pin routing,
// interrupt latch steering and capture timer input select.
// Assumes pins and peripheral signals are synchronous to clk_i; the
// port logic outside gates each pin with its own function control bit.
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Function
// - At most two of clocked serial, async serial zero, two-wire bus are active; none under reserved code 11.
// - Pair field codes 00, 01, 10 pick the pair; 11 is reserved.
// - Group bit puts async or clocked serial lines on port 2 or port B.
// - Timer field picks port7 bit2, port2 bit1 or port9 bit1 as timer input.
// - Two interrupt latches are shared between functions depending on pair.
// - Swap bit one exchanges async receive and transmit one on port 9.
// - Swap bit zero exchanges async receive and transmit zero in chosen group.
// - Latches seven, six and fifteen take sources according to pair code.
// - Two-wire and clocked serial use port 2 bits 3 to 5 by pair code.
module sps_mux
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Register port
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    // Muxed pins
    input wire logic [10:0] pin_in_i,
    input wire logic port7_bit2_i,
    output logic [10:0] pin_out_o,
    output logic [10:0] pin_oe_o,
    output logic [10:0] pin_serial_o,
    // Async serial zero
    input wire logic async_transmit_zero_i,
    output logic async_receive_zero_o,
    // Async serial one
    input wire logic async_transmit_one_i,
    output logic async_receive_one_o,
    // Clocked serial zero
    input wire logic clocked_serial_out_i,
    input wire logic clocked_serial_clock_i,
    input wire logic clocked_serial_clock_oe_i,
    output logic clocked_serial_in_o,
    output logic clocked_serial_clock_o,
    // Two-wire bus zero, open drain pulls low while enable is high
    input wire logic two_wire_data_oe_i,
    input wire logic two_wire_clock_oe_i,
    output logic two_wire_data_line_o,
    output logic two_wire_clock_line_o,
    // Capture timer
    output logic capture_timer_input_o,
    // Interrupt sources, one-cycle pulses
    input wire logic async_transmit_irq_i,
    input wire logic async_receive_irq_i,
    input wire logic two_wire_bus_irq_i,
    input wire logic clocked_serial_irq_i,
    // Interrupt latch set pulses
    output logic irq_latch_seven_o,
    output logic irq_latch_six_o,
    output logic irq_latch_fifteen_o
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------

    // Async serial zero is live in pair codes 00 and 01
    // pair code decode
    function automatic logic async_live(input logic [1:0] pair);
        async_live = (pair == sps_pkg::SPS_PAIR_ASYNC_TWI)
            || (pair == sps_pkg::SPS_PAIR_ASYNC_CSIO);
    endfunction

    // Two-wire bus is live in pair codes 00 and 10
    function automatic logic twi_live(input logic [1:0] pair);
        twi_live = (pair == sps_pkg::SPS_PAIR_ASYNC_TWI)
            || (pair == sps_pkg::SPS_PAIR_CSIO_TWI);
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] swap_ctrl_reg;
    logic [7:0] sel_ctrl_reg;
    logic [7:0] rdata_reg;
    logic [1:0] pair;
    logic group_sel;
    logic [1:0] tmr_sel;
    logic swap0;
    logic swap1;

    assign pair = sel_ctrl_reg[sps_pkg::PAIR_LSB +: 2];
    assign group_sel = sel_ctrl_reg[sps_pkg::GROUP_BIT];
    assign tmr_sel = sel_ctrl_reg[sps_pkg::TIMER_LSB +: 2];
    assign swap0 = swap_ctrl_reg[sps_pkg::SWAP0_BIT];
    assign swap1 = swap_ctrl_reg[sps_pkg::SWAP1_BIT];

    // Serial selection register write
    // read-only bits masked
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sel_ctrl_reg <= sps_pkg::SEL_CTRL_RESET;
        end
        else if (reg_write_i && reg_addr_i == sps_pkg::SEL_CTRL_ADDR)
        begin
            sel_ctrl_reg <= reg_wdata_i & sps_pkg::SEL_CTRL_WMASK;
        end
    end

    // Swap register write; no guard, software stops the uarts first
    // read-only bits masked
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            swap_ctrl_reg <= sps_pkg::SWAP_CTRL_RESET;
        end
        else if (reg_write_i && reg_addr_i == sps_pkg::SWAP_CTRL_ADDR)
        begin
            swap_ctrl_reg <= reg_wdata_i & sps_pkg::SWAP_CTRL_WMASK;
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_reg <= 8'h00;
        end
        else if (reg_read_i && reg_addr_i == sps_pkg::SEL_CTRL_ADDR)
        begin
            rdata_reg <= sel_ctrl_reg;
        end
        else if (reg_read_i && reg_addr_i == sps_pkg::SWAP_CTRL_ADDR)
        begin
            rdata_reg <= swap_ctrl_reg;
        end
        else
        begin
            rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // ------------------------------------------------------------
    // Pin routing
    // ------------------------------------------------------------
    logic [10:0] out_next;
    logic [10:0] oe_next;
    logic [10:0] sel_next;
    logic rx0_next;
    logic rx1_next;
    logic si_next;
    logic sclk_next;
    logic sda_next;
    logic scl_next;
    logic tmr_next;
    logic [3:0] base;
    logic [3:0] tx_idx;
    logic [3:0] rx_idx;

    // Idle levels: receive lines high, bus lines released high
    always_comb
    begin
        out_next = '0;
        oe_next = '0;
        sel_next = '0;
        rx0_next = 1'b1;
        rx1_next = 1'b1;
        si_next = 1'b0;
        sclk_next = 1'b0;
        sda_next = 1'b1;
        scl_next = 1'b1;
        base = group_sel ? sps_pkg::PIN_PORTB_BIT4 : sps_pkg::PIN_PORT2_BIT0;
        tx_idx = base + {3'h0, swap0};
        rx_idx = base + {3'h0, ~swap0};
        // async serial zero only in its pairs
        if (async_live(pair))
        begin
            sel_next[tx_idx] = 1'b1;
            sel_next[rx_idx] = 1'b1;
            out_next[tx_idx] = async_transmit_zero_i;
            oe_next[tx_idx] = 1'b1;
            rx0_next = pin_in_i[rx_idx];
        end
        // clocked serial on port 2 bits 3 to 5
        if (pair == sps_pkg::SPS_PAIR_ASYNC_CSIO)
        begin
            sel_next[sps_pkg::PIN_PORT2_BIT3] = 1'b1;
            sel_next[sps_pkg::PIN_PORT2_BIT4] = 1'b1;
            sel_next[sps_pkg::PIN_PORT2_BIT5] = 1'b1;
            out_next[sps_pkg::PIN_PORT2_BIT3] = clocked_serial_out_i;
            oe_next[sps_pkg::PIN_PORT2_BIT3] = 1'b1;
            si_next = pin_in_i[sps_pkg::PIN_PORT2_BIT4];
            out_next[sps_pkg::PIN_PORT2_BIT5] = clocked_serial_clock_i;
            oe_next[sps_pkg::PIN_PORT2_BIT5] = clocked_serial_clock_oe_i;
            sclk_next = pin_in_i[sps_pkg::PIN_PORT2_BIT5];
        end
        // clocked serial on the group pins, swap ignored
        if (pair == sps_pkg::SPS_PAIR_CSIO_TWI)
        begin
            sel_next[base] = 1'b1;
            sel_next[base + 4'h1] = 1'b1;
            sel_next[base + 4'h2] = 1'b1;
            out_next[base] = clocked_serial_out_i;
            oe_next[base] = 1'b1;
            si_next = pin_in_i[base + 4'h1];
            out_next[base + 4'h2] = clocked_serial_clock_i;
            oe_next[base + 4'h2] = clocked_serial_clock_oe_i;
            sclk_next = pin_in_i[base + 4'h2];
        end
        // two-wire bus on port 2 bits 3 and 4
        if (twi_live(pair))
        begin
            sel_next[sps_pkg::PIN_PORT2_BIT3] = 1'b1;
            sel_next[sps_pkg::PIN_PORT2_BIT4] = 1'b1;
            oe_next[sps_pkg::PIN_PORT2_BIT3] = two_wire_data_oe_i;
            oe_next[sps_pkg::PIN_PORT2_BIT4] = two_wire_clock_oe_i;
            sda_next = pin_in_i[sps_pkg::PIN_PORT2_BIT3];
            scl_next = pin_in_i[sps_pkg::PIN_PORT2_BIT4];
        end
        // async serial one on port 9, swappable
        sel_next[sps_pkg::PIN_PORT9_BIT0] = 1'b1;
        sel_next[sps_pkg::PIN_PORT9_BIT1] = 1'b1;
        if (swap1)
        begin
            out_next[sps_pkg::PIN_PORT9_BIT1] = async_transmit_one_i;
            oe_next[sps_pkg::PIN_PORT9_BIT1] = 1'b1;
            rx1_next = pin_in_i[sps_pkg::PIN_PORT9_BIT0];
        end
        else
        begin
            out_next[sps_pkg::PIN_PORT9_BIT0] = async_transmit_one_i;
            oe_next[sps_pkg::PIN_PORT9_BIT0] = 1'b1;
            rx1_next = pin_in_i[sps_pkg::PIN_PORT9_BIT1];
        end
        // timer input source, reserved code gives low
        unique case (tmr_sel)
            sps_pkg::SPS_TMR_PORT7_BIT2: tmr_next = port7_bit2_i;
            sps_pkg::SPS_TMR_PORT2_BIT1: tmr_next = pin_in_i[sps_pkg::PIN_PORT2_BIT1];
            sps_pkg::SPS_TMR_PORT9_BIT1: tmr_next = pin_in_i[sps_pkg::PIN_PORT9_BIT1];
            default: tmr_next = 1'b0;
        endcase
    end

    // Registered pin side; costs one cycle but keeps outputs glitch free
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pin_out_o <= '0;
            pin_oe_o <= '0;
            pin_serial_o <= '0;
        end
        else
        begin
            pin_out_o <= out_next;
            pin_oe_o <= oe_next;
            pin_serial_o <= sel_next;
        end
    end

    // Registered peripheral side
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            async_receive_zero_o <= 1'b1;
            async_receive_one_o <= 1'b1;
            clocked_serial_in_o <= 1'b0;
            clocked_serial_clock_o <= 1'b0;
            two_wire_data_line_o <= 1'b1;
            two_wire_clock_line_o <= 1'b1;
            capture_timer_input_o <= 1'b0;
        end
        else
        begin
            async_receive_zero_o <= rx0_next;
            async_receive_one_o <= rx1_next;
            clocked_serial_in_o <= si_next;
            clocked_serial_clock_o <= sclk_next;
            two_wire_data_line_o <= sda_next;
            two_wire_clock_line_o <= scl_next;
            capture_timer_input_o <= tmr_next;
        end
    end

    // ------------------------------------------------------------
    // Interrupt latch steering
    // ------------------------------------------------------------
    logic il7_next;
    logic il6_next;
    logic irq_latch_fifteen_next;

    // Sources of an inactive function are dropped, so a stray pulse
    // from a stopped controller cannot set a shared latch.
    // shared latch steering
    always_comb
    begin
        il7_next = 1'b0;
        il6_next = 1'b0;
        irq_latch_fifteen_next = 1'b0;
        unique case (pair)
            sps_pkg::SPS_PAIR_ASYNC_TWI:
            begin
                il7_next = async_transmit_irq_i;
                il6_next = async_receive_irq_i;
                irq_latch_fifteen_next = two_wire_bus_irq_i;
            end
            sps_pkg::SPS_PAIR_ASYNC_CSIO:
            begin
                il7_next = async_transmit_irq_i;
                il6_next = async_receive_irq_i;
                irq_latch_fifteen_next = clocked_serial_irq_i;
            end
            sps_pkg::SPS_PAIR_CSIO_TWI:
            begin
                il6_next = clocked_serial_irq_i;
                irq_latch_fifteen_next = two_wire_bus_irq_i;
            end
            default:
            begin
                il7_next = 1'b0;
            end
        endcase
    end

    // One-cycle set pulses toward the latches
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            irq_latch_seven_o <= 1'b0;
            irq_latch_six_o <= 1'b0;
            irq_latch_fifteen_o <= 1'b0;
        end
        else
        begin
            irq_latch_seven_o <= il7_next;
            irq_latch_six_o <= il6_next;
            irq_latch_fifteen_o <= irq_latch_fifteen_next;
        end
    end

endmodule

`default_nettype wire

// >>> sps_mux_properties.sv
// Port checker for the serial pin select mux.
// Assumes one register strobe at a time and pins synchronous to clk_i.
`timescale 1ns/100ps
`default_nettype none
module sps_mux_check
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Register port
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    // Pins and peripherals
    input wire logic [10:0] pin_in_i,
    input wire logic port7_bit2_i,
    input wire logic [10:0] pin_out_o,
    input wire logic [10:0] pin_oe_o,
    input wire logic async_transmit_one_i,
    input wire logic async_receive_zero_o,
    input wire logic async_receive_one_o,
    input wire logic two_wire_data_oe_i,
    input wire logic capture_timer_input_o,
    // Interrupts
    input wire logic async_transmit_irq_i,
    input wire logic async_receive_irq_i,
    input wire logic two_wire_bus_irq_i,
    input wire logic clocked_serial_irq_i,
    input wire logic irq_latch_seven_o,
    input wire logic irq_latch_six_o,
    input wire logic irq_latch_fifteen_o
);
    logic [7:0] sel_m;
    logic [1:0] swp_m;
    logic live;
    logic [1:0] pr;
    logic [7:0] erd;
    logic e7, e6, e15, etmr, erx0, erx1;
    // Register mirror; live skips the first edge, where outputs still hold reset values
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sel_m <= 8'h00;
            swp_m <= 2'h0;
            live <= 1'b0;
        end
        else
        begin
            live <= 1'b1;
            if (reg_write_i && reg_addr_i == sps_pkg::SEL_CTRL_ADDR)
                sel_m <= reg_wdata_i & sps_pkg::SEL_CTRL_WMASK;
            if (reg_write_i && reg_addr_i == sps_pkg::SWAP_CTRL_ADDR)
                swp_m <= reg_wdata_i[1:0];
        end
    end
    // Expected routing from mirror and inputs
    always_comb
    begin
        pr = sel_m[1:0];
        erd = (reg_addr_i == sps_pkg::SEL_CTRL_ADDR) ? sel_m :
            (reg_addr_i == sps_pkg::SWAP_CTRL_ADDR) ? {6'h00, swp_m} : 8'h00;
        e7 = (pr < 2'h2) && async_transmit_irq_i;
        e6 = (pr < 2'h2) ? async_receive_irq_i : (pr == 2'h2) && clocked_serial_irq_i;
        e15 = (pr == 2'h1) ? clocked_serial_irq_i : (pr != 2'h3) && two_wire_bus_irq_i;
        etmr = (sel_m[7:6] == 2'h0) ? port7_bit2_i : (sel_m[7:6] == 2'h1) ? pin_in_i[1] :
            (sel_m[7:6] == 2'h2) && pin_in_i[10];
        erx0 = pin_in_i[(sel_m[4] ? 4'h6 : 4'h0) + {3'h0, !swp_m[0]}];
        erx1 = swp_m[1] ? pin_in_i[9] : pin_in_i[10];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i || !live);
    a_rdata_idle_zero: assert property (!$past(reg_read_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside answer cycle");
    a_read_back_value: assert property (reg_read_i |=> reg_rdata_o == $past(erd))
        else $error("read data differs from written value");
    a_irq_seven_route: assert property (irq_latch_seven_o == $past(e7))
        else $error("latch seven pulse wrong");
    a_irq_six_route: assert property ($past(e6) |-> irq_latch_six_o)
        else $error("latch six pulse missing");
    a_irq_six_quiet: assert property (!e6 |=> !irq_latch_six_o)
        else $error("latch six pulse unexpected");
    a_irq_fifteen_route: assert property (irq_latch_fifteen_o == $past(e15))
        else $error("latch fifteen pulse wrong");
    a_timer_input_sel: assert property (capture_timer_input_o == $past(etmr))
        else $error("timer input wrong");
    a_uart_one_rx: assert property (async_receive_one_o == $past(erx1))
        else $error("uart one receive wrong");
    a_uart_one_tx: assert property (pin_out_o[$past(swp_m[1]) ? 10 : 9] == $past(async_transmit_one_i))
        else $error("uart one transmit pin wrong");
    a_uart_zero_rx: assert property ($past(pr < 2'h2) |-> async_receive_zero_o == $past(erx0))
        else $error("uart zero receive wrong");
    a_twi_data_pull: assert property ($past(pr[0] == 1'b0) |-> pin_oe_o[3] == $past(two_wire_data_oe_i))
        else $error("two-wire data drive wrong");
endmodule
bind sps_mux sps_mux_check CHK (.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
    .reg_read_i, .reg_rdata_o, .pin_in_i, .port7_bit2_i, .pin_out_o, .pin_oe_o,
    .async_transmit_one_i, .async_receive_zero_o, .async_receive_one_o, .two_wire_data_oe_i,
    .capture_timer_input_o, .async_transmit_irq_i, .async_receive_irq_i, .two_wire_bus_irq_i,
    .clocked_serial_irq_i, .irq_latch_seven_o, .irq_latch_six_o, .irq_latch_fifteen_o);
`default_nettype wire

// >>> sps_pin_model.sv
// Port pin model for the mux's pin side.
// Assumes outside levels come from the bench; open drain pins pull up outside.
`timescale 1ns/100ps
`default_nettype none
module sps_pin_model
(
    // Mux side
    input wire logic [10:0] pin_out_i,
    input wire logic [10:0] pin_oe_i,
    // Outside world
    input wire logic [10:0] ext_lvl_i,
    output logic [10:0] pin_lvl_o
);
    always_comb
    begin
        for (int i = 0; i < 11; i++)
            pin_lvl_o[i] = pin_oe_i[i] ? pin_out_i[i] : ext_lvl_i[i];
    end
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the serial pin select mux.
// Assumes the pin model resolves every muxed pin.
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [11:0] SEL = sps_pkg::SEL_CTRL_ADDR;
    localparam logic [11:0] SWP = sps_pkg::SWAP_CTRL_ADDR;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_write_i = 1'b0, reg_read_i = 1'b0, port7_bit2_i = 1'b0;
    logic async_transmit_zero_i = 1'b1, async_transmit_one_i = 1'b1, clocked_serial_out_i = 1'b0;
    logic two_wire_data_oe_i = 1'b0;
    logic [3:0] irq_src = 4'h0;
    logic [10:0] ext_lvl = 11'h7ff;
    logic [10:0] pin_in_i, pin_out_o, pin_oe_o, pin_serial_o;
    logic [7:0] reg_rdata_o;
    logic async_receive_zero_o, async_receive_one_o, clocked_serial_in_o, clocked_serial_clock_o;
    logic two_wire_data_line_o, two_wire_clock_line_o, capture_timer_input_o;
    logic irq_latch_seven_o, irq_latch_six_o, irq_latch_fifteen_o;
    int failures = 0;
    int n_checks = 0;
    // Clock at 20 MHz
    always #25 clk_i = ~clk_i;
    sps_pin_model PINS (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_lvl_i(ext_lvl),
        .pin_lvl_o(pin_in_i));
    // Serial clock drives with serial out and pulls with the data pull, so few inputs reach all paths
    sps_mux DUT (.clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
        .reg_rdata_o, .pin_in_i, .port7_bit2_i, .pin_out_o, .pin_oe_o, .pin_serial_o,
        .async_transmit_zero_i, .async_receive_zero_o, .async_transmit_one_i, .async_receive_one_o,
        .clocked_serial_out_i, .clocked_serial_clock_i(clocked_serial_out_i),
        .clocked_serial_clock_oe_i(two_wire_data_oe_i),
        .clocked_serial_in_o, .clocked_serial_clock_o, .two_wire_data_oe_i,
        .two_wire_clock_oe_i(two_wire_data_oe_i), .two_wire_data_line_o, .two_wire_clock_line_o,
        .capture_timer_input_o, .async_transmit_irq_i(irq_src[0]), .async_receive_irq_i(irq_src[1]),
        .two_wire_bus_irq_i(irq_src[2]), .clocked_serial_irq_i(irq_src[3]),
        .irq_latch_seven_o, .irq_latch_six_o, .irq_latch_fifteen_o);
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1;
        chk({3'h0, reg_rdata_o}, {3'h0, e});
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task automatic t_regs;
        rd(SEL, 8'h00);
        rd(SWP, 8'h00);
        wr(SEL, 8'hfe);
        rd(SEL, 8'hd2);
        wr(SWP, 8'hff);
        rd(SWP, 8'h03);
        wr(12'hf58, 8'hff);
        rd(12'hf58, 8'h00);
        wr(SWP, 8'h00);
        $display("test regs done");
    endtask
    // Peripheral inputs keep their previous values while the selection changes
    task automatic t_route;
        logic [3:0] b;
        for (int p = 0; p < 3; p++)
            for (int g = 0; g < 2; g++)
                for (int s = 0; s < 2; s++)
                begin
                    wr(SEL, {3'h0, g[0], 2'h0, p[1:0]});
                    wr(SWP, {7'h00, s[0]});
                    @(posedge clk_i);
                    ext_lvl <= 11'h5ad ^ {11{s[0]}};
                    async_transmit_zero_i <= !s[0];
                    clocked_serial_out_i <= s[0];
                    two_wire_data_oe_i <= g[0];
                    settle;
                    b = g[0] ? 4'h6 : 4'h0;
                    if (p < 2)
                    begin
                        chk(async_receive_zero_o, ext_lvl[b + {3'h0, !s[0]}]);
                        chk(pin_out_o[b + {3'h0, s[0]}], !s[0]);
                        chk(pin_serial_o[b], 1'b1);
                    end
                    if (p == 2)
                    begin
                        chk(pin_out_o[b], s[0]);
                        chk(clocked_serial_in_o, ext_lvl[b + 4'h1]);
                        chk(clocked_serial_clock_o, g[0] ? s[0] : ext_lvl[b + 4'h2]);
                    end
                    if (p == 1)
                    begin
                        chk(pin_out_o[3], s[0]);
                        chk(clocked_serial_in_o, ext_lvl[4]);
                        chk(clocked_serial_clock_o, g[0] ? s[0] : ext_lvl[5]);
                    end
                    else
                    begin
                        chk(two_wire_data_line_o, !g[0] && ext_lvl[3]);
                        chk(two_wire_clock_line_o, !g[0] && ext_lvl[4]);
                    end
                end
        $display("test route done");
    endtask
    task automatic t_irq;
        logic e7, e6, e15;
        for (int p = 0; p < 3; p++)
        begin
            wr(SEL, {6'h00, p[1:0]});
            for (int k = 0; k < 4; k++)
            begin
                @(posedge clk_i);
                irq_src <= 4'h1 << k;
                @(posedge clk_i);
                irq_src <= 4'h0;
                #1;
                e7 = p < 2 && k == 0;
                e6 = (p < 2 && k == 1) || (p == 2 && k == 3);
                e15 = p != 3 && ((k == 2 && p != 1) || (k == 3 && p == 1));
                chk({irq_latch_fifteen_o, irq_latch_six_o, irq_latch_seven_o}, {e15, e6, e7});
            end
        end
        $display("test irq done");
    endtask
    task automatic t_timer;
        wr(SWP, 8'h00);
        for (int t = 0; t < 4; t++)
        begin
            wr(SEL, {t[1:0], 6'h00});
            for (int v = 0; v < 4; v++)
            begin
                @(posedge clk_i);
                port7_bit2_i <= v[0];
                ext_lvl <= {!v[0], 8'h00, v[1], 1'b0};
                settle;
                chk(capture_timer_input_o, t == 0 ? v[0] : t == 1 ? v[1] : t == 2 && !v[0]);
            end
        end
        $display("test timer done");
    endtask
    task automatic t_uart1;
        for (int s = 0; s < 2; s++)
        begin
            wr(SWP, {6'h00, s[0], 1'b0});
            for (int v = 0; v < 2; v++)
            begin
                @(posedge clk_i);
                async_transmit_one_i <= v[0];
                ext_lvl <= {!v[0], v[0], 9'h000};
                settle;
                chk(async_receive_one_o, s[0] ? v[0] : !v[0]);
                chk(pin_out_o[s[0] ? 10 : 9], v[0]);
            end
        end
        $display("test uart one done");
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence after a 16-cycle reset
    initial
    begin
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_regs;
        t_route;
        t_irq;
        t_timer;
        t_uart1;
        complete_run;
    end
    // Watchdog well beyond the roughly 250 cycles the tests need
    initial
    begin
        #500000;
        failures++;
        complete_run;
    end
endmodule
`default_nettype wire
